// ### ssp_defines.vh
// Operation
// - Slave interface works only while config bit 0 is set; otherwise disabled.
// - Output data launched on falling edge if bit 15 clear, rising if set.
// - Input data sampled on falling edge if bit 14 clear, rising if set.
// - Bits 9:8 advance output timing by up to 2 serial cycles; default 2.
// - Bits 7:1 delay the output driver by that many core clock cycles.
// - Driver delay settings 0 and 1 both give about 2 core cycles at pad.
// - Config register resets to 0200 hex: disabled, falling edges, advance 2.
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// ----------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------
`define SSP_AW            16
`define SSP_ADDR_CFG      16'hf580
`define SSP_ADDR_RXDATA   16'hf584
`define SSP_ADDR_TXDATA   16'hf588
`define SSP_ADDR_STATUS   16'hf58c

// ----------------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------------
`define SSP_CFG_RESET     16'h0200
`define SSP_CFG_WMASK     16'hc3ff
`define SSP_CFG_EN        0
`define SSP_CFG_DLY_LO    1
`define SSP_CFG_DLY_HI    7
`define SSP_CFG_ADV_LO    8
`define SSP_CFG_ADV_HI    9
`define SSP_CFG_IN_SEL    14
`define SSP_CFG_OUT_SEL   15

// ----------------------------------------------------------------------
// Status fields and data path
// ----------------------------------------------------------------------
`define SSP_ST_EMPTY      0
`define SSP_ST_FULL       1
`define SSP_ST_OVF        2
`define SSP_ST_FRAME      3
`define SSP_ST_CNT_LO     8
`define SSP_ST_CNT_HI     12
`define SSP_TX_RESET      8'hff
`define SSP_DATA_W        8
`define SSP_FIFO_DEPTH    16
`define SSP_FIFO_AW       4
`define SSP_ADV_MAX       2'h2
`define SSP_BITS_PER_BYTE 3'h7

`endif

// ### ssp_sync.v
`timescale 1ns/1ns
`default_nettype none

module ssp_sync #(
  parameter W = 1
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);

  reg [W-1:0] s1_ff;
  reg [W-1:0] s2_ff;
  reg [W-1:0] s3_ff;

  // Three stages; output follows once stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= {W{1'b1}};
      s2_ff <= {W{1'b1}};
      s3_ff <= {W{1'b1}};
      dout  <= {W{1'b1}};
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      dout  <= (s2_ff & s3_ff) | (dout & (s2_ff ^ s3_ff));
    end
  end

endmodule
`default_nettype wire

// ### ssp_fifo.v
`timescale 1ns/1ns
`default_nettype none

module ssp_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             pclk,
  input  wire             presetn,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data,
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_ff;
  reg [AW-1:0]    rd_ptr_ff;
  reg [AW:0]      cnt_ff;
  wire            push;
  wire            pop;

  assign in_ready  = (cnt_ff != DEPTH[AW:0]);
  assign out_valid = (cnt_ff != {(AW+1){1'b0}});
  assign out_data  = mem_ff[rd_ptr_ff];
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Storage write
  always @(posedge pclk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

  // Pointers and fill count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      cnt_ff    <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### ssp_top.v
`include "ssp_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module ssp_top (
  input  wire                  pclk,
  input  wire                  presetn,
  input  wire                  psel,
  input  wire                  penable,
  input  wire                  pwrite,
  input  wire [`SSP_AW-1:0]    paddr,
  input  wire [31:0]           pwdata,
  output reg  [31:0]           prdata_ff,
  output reg                   pready_ff,
  output reg                   pslverr_ff,
  input  wire                  spi_sck,
  input  wire                  spi_cs_n,
  input  wire                  spi_sdi,
  output reg                   spi_sdo_ff,
  output reg                   spi_sdo_oe_ff
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  reg  [15:0]              cfg_ff;
  reg  [7:0]               tx_data_ff;
  reg                      ovf_ff;
  reg                      sck_prev_ff;
  reg                      cs_prev_ff;
  reg  [7:0]               rx_shift_ff;
  reg  [2:0]               rx_cnt_ff;
  reg  [7:0]               tx_shift_ff;
  reg  [2:0]               tx_cnt_ff;
  reg                      sampled_ff;
  reg  [1:0]               adv_pipe_ff;
  reg                      pend_bit_ff;
  reg                      pend_oe_ff;
  reg  [6:0]               dly_cnt_ff;
  reg                      dly_busy_ff;
  reg                      push_ff;
  reg  [7:0]               push_data_ff;
  reg  [7:0]               nxt_rx_shift;
  reg  [31:0]              nxt_prdata;
  reg                      nxt_slverr;
  reg                      out_bit;
  wire [2:0]               pin_lvl;
  wire                     sck_lvl;
  wire                     cs_lvl;
  wire                     sdi_lvl;
  wire                     cfg_en;
  wire                     out_sel;
  wire                     in_sel;
  wire [1:0]               cfg_adv;
  wire [6:0]               cfg_dly;
  wire                     sck_rise;
  wire                     sck_fall;
  wire                     in_frame;
  wire                     frame_start;
  wire                     sample_edge;
  wire                     launch_edge;
  wire                     setup_ph;
  wire                     access_done;
  wire                     wr_done;
  wire                     rd_done;
  wire                     fifo_in_ready;
  wire                     fifo_out_valid;
  wire [7:0]               fifo_out_data;
  wire [`SSP_FIFO_AW:0]    fifo_level;
  wire                     pop_req;
  wire                     ovf_set;

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------

  // Address compare on the word address
  function addr_hit;
    input [`SSP_AW-1:0] a;
    input [`SSP_AW-1:0] b;
    begin
      addr_hit = (a[`SSP_AW-1:2] == b[`SSP_AW-1:2]);
    end
  endfunction

  // Extra core cycles before the pad follows a launch
  function [6:0] drv_wait;
    input [6:0] dly;
    begin
      if (dly <= 7'h01) begin
        drv_wait = 7'h00;
      end else begin
        drv_wait = dly - 7'h01;
      end
    end
  endfunction

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  ssp_sync #(
    .W (3)
  ) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     ({spi_sck, spi_cs_n, spi_sdi}),
    .dout    (pin_lvl)
  );

  assign sck_lvl = pin_lvl[2];
  assign cs_lvl  = pin_lvl[1];
  assign sdi_lvl = pin_lvl[0];

  // --------------------------------------------------------------------
  // Configuration decode
  // --------------------------------------------------------------------
  assign cfg_en  = cfg_ff[`SSP_CFG_EN];
  assign out_sel = cfg_ff[`SSP_CFG_OUT_SEL];
  assign in_sel  = cfg_ff[`SSP_CFG_IN_SEL];
  assign cfg_adv = cfg_ff[`SSP_CFG_ADV_HI:`SSP_CFG_ADV_LO];
  assign cfg_dly = cfg_ff[`SSP_CFG_DLY_HI:`SSP_CFG_DLY_LO];

  // Edge detection on the filtered serial clock
  assign sck_rise    = sck_lvl & ~sck_prev_ff;
  assign sck_fall    = ~sck_lvl & sck_prev_ff;
  assign in_frame    = cfg_en & ~cs_lvl;
  assign frame_start = in_frame & cs_prev_ff;
  assign sample_edge = in_frame & (in_sel ? sck_rise : sck_fall);
  assign launch_edge = in_frame & (out_sel ? sck_rise : sck_fall);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_ff <= 1'b1;
      cs_prev_ff  <= 1'b1;
    end else begin
      sck_prev_ff <= sck_lvl;
      cs_prev_ff  <= cs_lvl;
    end
  end

  // --------------------------------------------------------------------
  // Receive path
  // --------------------------------------------------------------------

  // Next receive shift value
  always @* begin
    nxt_rx_shift = {rx_shift_ff[6:0], sdi_lvl};
  end

  // Shift in bits, hand each full byte to the buffer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_shift_ff  <= 8'h00;
      rx_cnt_ff    <= 3'h0;
      push_ff      <= 1'b0;
      push_data_ff <= 8'h00;
    end else begin
      push_ff <= 1'b0;
      if (!in_frame) begin
        rx_cnt_ff <= 3'h0;
      end else if (sample_edge) begin
        rx_shift_ff <= nxt_rx_shift;
        rx_cnt_ff   <= rx_cnt_ff + 3'h1;
        if (rx_cnt_ff == `SSP_BITS_PER_BYTE) begin
          push_ff      <= 1'b1;
          push_data_ff <= nxt_rx_shift;
        end
      end
    end
  end

  // Receive buffer
  ssp_fifo #(
    .WIDTH (`SSP_DATA_W),
    .DEPTH (`SSP_FIFO_DEPTH),
    .AW    (`SSP_FIFO_AW)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (push_ff),
    .in_ready  (fifo_in_ready),
    .in_data   (push_data_ff),
    .out_valid (fifo_out_valid),
    .out_ready (pop_req),
    .out_data  (fifo_out_data),
    .level     (fifo_level)
  );

  // Overflow when a byte finds the buffer full
  assign ovf_set = push_ff & ~fifo_in_ready;

  // --------------------------------------------------------------------
  // Transmit path
  // --------------------------------------------------------------------

  // Byte shifting, launched only after a sample in the same bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_shift_ff <= 8'h00;
      tx_cnt_ff   <= 3'h0;
      sampled_ff  <= 1'b0;
      adv_pipe_ff <= 2'h0;
    end else begin
      if (frame_start) begin
        tx_shift_ff <= tx_data_ff;
        tx_cnt_ff   <= 3'h0;
        sampled_ff  <= 1'b0;
        adv_pipe_ff <= {2{tx_data_ff[7]}};
      end else if (in_frame) begin
        if (sample_edge) begin
          sampled_ff <= 1'b1;
        end
        if (launch_edge && sampled_ff) begin
          sampled_ff  <= sample_edge;
          adv_pipe_ff <= {adv_pipe_ff[0], tx_shift_ff[7]};
          tx_cnt_ff   <= tx_cnt_ff + 3'h1;
          if (tx_cnt_ff == `SSP_BITS_PER_BYTE) begin
            tx_shift_ff <= tx_data_ff;
          end else begin
            tx_shift_ff <= {tx_shift_ff[6:0], 1'b0};
          end
        end
      end
    end
  end

  // Advance select: two is earliest, zero lags two launch edges
  always @* begin
    case (cfg_adv)
      2'h0: out_bit = adv_pipe_ff[1];
      2'h1: out_bit = adv_pipe_ff[0];
      default: out_bit = tx_shift_ff[7];
    endcase
  end

  // --------------------------------------------------------------------
  // Output driver delay
  // --------------------------------------------------------------------

  // Hold the wanted pad value, release after the programmed wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_bit_ff   <= 1'b0;
      pend_oe_ff    <= 1'b0;
      dly_cnt_ff    <= 7'h00;
      dly_busy_ff   <= 1'b0;
      spi_sdo_ff    <= 1'b0;
      spi_sdo_oe_ff <= 1'b0;
    end else begin
      if ((out_bit != pend_bit_ff) || (in_frame != pend_oe_ff)) begin
        pend_bit_ff <= out_bit;
        pend_oe_ff  <= in_frame;
        dly_cnt_ff  <= drv_wait(cfg_dly);
        dly_busy_ff <= 1'b1;
      end else if (dly_busy_ff) begin
        if (dly_cnt_ff == 7'h00) begin
          spi_sdo_ff    <= pend_bit_ff;
          spi_sdo_oe_ff <= pend_oe_ff;
          dly_busy_ff   <= 1'b0;
        end else begin
          dly_cnt_ff <= dly_cnt_ff - 7'h01;
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  assign setup_ph    = psel & ~penable;
  assign access_done = psel & penable & pready_ff;
  assign wr_done     = access_done & pwrite & ~pslverr_ff;
  assign rd_done     = access_done & ~pwrite & ~pslverr_ff;
  assign pop_req     = rd_done & addr_hit(paddr, `SSP_ADDR_RXDATA);

  // Read data and error decode during setup
  always @* begin
    nxt_prdata = 32'h0000_0000;
    nxt_slverr = 1'b0;
    if (addr_hit(paddr, `SSP_ADDR_CFG)) begin
      nxt_prdata = {16'h0000, cfg_ff & `SSP_CFG_WMASK};
    end else if (addr_hit(paddr, `SSP_ADDR_RXDATA)) begin
      nxt_prdata = {24'h000000, fifo_out_data & {8{fifo_out_valid}}};
    end else if (addr_hit(paddr, `SSP_ADDR_TXDATA)) begin
      nxt_prdata = {24'h000000, tx_data_ff};
    end else if (addr_hit(paddr, `SSP_ADDR_STATUS)) begin
      nxt_prdata[`SSP_ST_EMPTY] = ~fifo_out_valid;
      nxt_prdata[`SSP_ST_FULL]  = ~fifo_in_ready;
      nxt_prdata[`SSP_ST_OVF]   = ovf_ff;
      nxt_prdata[`SSP_ST_FRAME] = in_frame;
      nxt_prdata[`SSP_ST_CNT_HI:`SSP_ST_CNT_LO] = fifo_level;
    end else begin
      nxt_slverr = 1'b1;
    end
  end

  // One wait-free access phase after each setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff <= setup_ph;
      if (setup_ph) begin
        pslverr_ff <= nxt_slverr;
        prdata_ff  <= pwrite ? 32'h0000_0000 : nxt_prdata;
      end else if (access_done) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Register writes and sticky overflow, set beats clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff     <= `SSP_CFG_RESET;
      tx_data_ff <= `SSP_TX_RESET;
      ovf_ff     <= 1'b0;
    end else begin
      if (wr_done && addr_hit(paddr, `SSP_ADDR_CFG)) begin
        cfg_ff <= pwdata[15:0] & `SSP_CFG_WMASK;
      end
      if (wr_done && addr_hit(paddr, `SSP_ADDR_TXDATA)) begin
        tx_data_ff <= pwdata[7:0];
      end
      if (ovf_set) begin
        ovf_ff <= 1'b1;
      end else if (wr_done && addr_hit(paddr, `SSP_ADDR_STATUS) &&
                   pwdata[`SSP_ST_OVF]) begin
        ovf_ff <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### ssp_top_asserts.sv
`include "ssp_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module ssp_top_asserts (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [`SSP_AW-1:0] paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata_ff,
  input wire logic               pready_ff,
  input wire logic               pslverr_ff,
  input wire logic               spi_sck,
  input wire logic               spi_cs_n,
  input wire logic               spi_sdi,
  input wire logic               spi_sdo_ff,
  input wire logic               spi_sdo_oe_ff
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // Shadow of the config register and idle counter
  // ----------------------------------------------------------------
  logic [15:0] cfg_ff;
  logic [7:0]  idle_ff;
  logic        mapped;
  logic        done;
  assign mapped = paddr == `SSP_ADDR_CFG || paddr == `SSP_ADDR_RXDATA ||
                  paddr == `SSP_ADDR_TXDATA || paddr == `SSP_ADDR_STATUS;
  assign done = psel && penable && pready_ff;

  // Track config writes and cycles without a live frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff  <= `SSP_CFG_RESET;
      idle_ff <= 8'h00;
    end else begin
      if (done && pwrite && paddr == `SSP_ADDR_CFG)
        cfg_ff <= pwdata[15:0] & `SSP_CFG_WMASK;
      if (!spi_cs_n && cfg_ff[0])
        idle_ff <= 8'h00;
      else if (idle_ff != 8'hff)
        idle_ff <= idle_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // Bus and link assertions
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_cfg_read;
    done && !pwrite && paddr == `SSP_ADDR_CFG;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready_ff)
    else $error("no answer after setup");
  a_ready_one_pulse: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  a_cfg_read_back: assert property (s_cfg_read |-> prdata_ff == {16'h0000, cfg_ff})
    else $error("config read mismatch");
  a_unmapped_error: assert property (done && !mapped |-> pslverr_ff && (pwrite || prdata_ff == 0))
    else $error("unmapped access not refused");
  a_mapped_no_error: assert property (done && mapped |-> !pslverr_ff)
    else $error("mapped access refused");
  a_oe_needs_frame: assert property ($rose(spi_sdo_oe_ff) |-> cfg_ff[0] && !$past(spi_cs_n, 3))
    else $error("driver on outside frame");
  a_idle_no_drive: assert property (idle_ff >= 8'd200 |-> !spi_sdo_oe_ff)
    else $error("driver on while idle");
  a_short_drive_delay: assert property ($fell(spi_cs_n) && cfg_ff[0] && cfg_ff[7:1] < 7'd2 |-> ##[2:9] spi_sdo_oe_ff)
    else $error("short driver delay wrong");
endmodule

bind ssp_top ssp_top_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
  .pslverr_ff(pslverr_ff), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
  .spi_sdo_ff(spi_sdo_ff), .spi_sdo_oe_ff(spi_sdo_oe_ff)
);

`default_nettype wire

// ### ssp_spi_master.sv
`timescale 1ns/1ns
`default_nettype none

module ssp_spi_master (
  input  wire logic pclk,
  output var  logic spi_sck,
  output var  logic spi_cs_n,
  output var  logic spi_sdi,
  input  wire logic spi_sdo_ff,
  input  wire logic spi_sdo_oe_ff
);
  initial begin
    spi_sck  = 1'b1;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b1;
  end

  // One byte frame, MSB first, 80 ns clock; undriven bits read as x
  // Each bit is read at the end of its period, just before the next launch:
  // the port answers several core cycles after each synchronised edge
  task automatic xfer(input logic rise_smp, input logic [7:0] tx, output logic [7:0] rx);
    @(posedge pclk);
    spi_cs_n <= 1'b0;
    spi_sdi  <= tx[7];
    repeat (8) @(posedge pclk);
    for (int i = 7; i >= 0; i--) begin
      spi_sck <= 1'b0;
      if (rise_smp)
        spi_sdi <= tx[i];
      repeat (4) @(posedge pclk);
      spi_sck <= 1'b1;
      if (!rise_smp && i > 0)
        spi_sdi <= tx[i-1];
      repeat (4) @(posedge pclk);
      rx[i] = spi_sdo_oe_ff ? spi_sdo_ff : 1'bx;
    end
    spi_cs_n <= 1'b1;
    spi_sdi  <= ~tx[0]; // Released line shows no stale value
    repeat (8) @(posedge pclk);
  endtask
endmodule

`default_nettype wire

// ### spi_slave_port_config_bench.sv
`include "ssp_defines.vh"
`timescale 1ns/1ns
`default_nettype none

module spi_slave_port_config_bench;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        spi_sck;
  logic        spi_cs_n;
  logic        spi_sdi;
  logic        spi_sdo_ff;
  logic        spi_sdo_oe_ff;
  logic        err;
  logic [31:0] r;
  logic [7:0]  rx;
  logic [15:0] cfg;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #5 pclk = ~pclk;

  ssp_top DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata_ff), .pready_ff(pready_ff),
    .pslverr_ff(pslverr_ff), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo_ff(spi_sdo_ff), .spi_sdo_oe_ff(spi_sdo_oe_ff)
  );

  ssp_spi_master master (
    .pclk(pclk), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi),
    .spi_sdo_ff(spi_sdo_ff), .spi_sdo_oe_ff(spi_sdo_oe_ff)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checked %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // APB transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready_ff !== 1'b1 && n < 50);
    if (pready_ff !== 1'b1) begin
      miscompares++;
      $display("Error at %0t: no bus answer", $time);
    end
    r   = prdata_ff;
    err = pslverr_ff;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // Timeout guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc >= 20000) begin
      miscompares++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(0, `SSP_ADDR_CFG, 0);
    check(r, 32'h0000_0200);
    apb(1, `SSP_ADDR_CFG, 32'h0000_ffff);
    apb(0, `SSP_ADDR_CFG, 0);
    check(r, 32'h0000_c3ff);
    apb(0, 16'hf590, 0);
    check({r[30:0], err}, 32'h0000_0001);
    // Disabled port takes nothing in
    apb(1, `SSP_ADDR_CFG, 32'h0000_4200);
    master.xfer(1, 8'h3c, rx);
    apb(0, `SSP_ADDR_STATUS, 0);
    check(r, 32'h0000_0001);
    // Both edge modes, driver delay 0 and 1
    for (int k = 0; k < 4; k++) begin
      cfg = (k[1] ? 16'h8201 : 16'h4201) | {14'h0, k[0], 1'b0};
      apb(1, `SSP_ADDR_CFG, {16'h0, cfg});
      apb(1, `SSP_ADDR_TXDATA, 32'ha5 ^ k);
      master.xfer(!k[1], 8'h3c + k, rx);
      check(rx, 8'ha5 ^ k);
      apb(0, `SSP_ADDR_RXDATA, 0);
      check(r, 8'h3c + k);
    end
    // Output advance one and zero: first bit shown for one or two extra bits
    apb(1, `SSP_ADDR_CFG, 32'h0000_4101);
    apb(1, `SSP_ADDR_TXDATA, 32'h96);
    master.xfer(1, 8'h5a, rx);
    check(rx, 8'hcb);
    apb(1, `SSP_ADDR_CFG, 32'h0000_4001);
    master.xfer(1, 8'h69, rx);
    check(rx, 8'he5);
    apb(0, `SSP_ADDR_RXDATA, 0);
    check(r, 8'h5a);
    apb(0, `SSP_ADDR_RXDATA, 0);
    check(r, 8'h69);
    // Fill past full, then drain
    apb(1, `SSP_ADDR_CFG, 32'h0000_4201);
    for (int j = 0; j < 17; j++)
      master.xfer(1, j, rx);
    apb(0, `SSP_ADDR_STATUS, 0);
    check(r, 32'h0000_1006);
    for (int j = 0; j < 16; j++) begin
      apb(0, `SSP_ADDR_RXDATA, 0);
      check(r, j);
    end
    apb(0, `SSP_ADDR_STATUS, 0);
    check(r, 32'h0000_0005);
    apb(1, `SSP_ADDR_STATUS, 32'h4);
    apb(0, `SSP_ADDR_STATUS, 0);
    check(r, 32'h0000_0001);
    finish_test();
  end
endmodule

`default_nettype wire
